//--- cscd_top.sv
// Purpose: Latches rate, mode and station switches once after power-on,
//   decodes them, flags bad rate settings and relays I/O exchange data.
// Assumes: SYS_RST is the power-on reset; error events are same-clock pulses.
// Notes: APB slave with zero wait states; unmapped addresses give PSLVERR.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps

// How it works
// RULE_01 - Switches captured only once after power-on
// RULE_02 - Rate switch seven selects 625 kbps
// RULE_03 - Rate eight or higher raises setting alarm
// RULE_04 - Rates zero to six raise no alarm
// RULE_05 - Mode bit one picks 16/8-bit occupied size
// RULE_06 - Mode bits two, three give byte count
// RULE_07 - Mode bit four is ignored
// RULE_08 - Station number is tens digit, ones digit
// RULE_09 - Operator keeps station within 03h to EFh
// RULE_10 - Operator keeps station numbers unique
// RULE_11 - Drives must run at 625 kbps
// RULE_12 - Connection enable applies after power cycle
// RULE_13 - Serial and fieldbus errors light separate indicators
// RULE_14 - Command 20h relays drive I/O signals
// RULE_15 - Configuration stable; alarm within fixed cycles
// RULE_16 - Master connects with 0Eh, releases with 0Fh; codes 0Eh and 0Fh are ignored here, only 20h is decoded
module cscd_top (
  input wire logic CLK, // system clock, 250 MHz
  input wire logic SYS_RST, // synchronous power-on reset
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input wire logic [3:0] RATE_SW, // rate_select_switch pins
  input wire logic [3:0] MODE_SW, // mode_select_switch pins
  input wire logic [3:0] STN_TENS_SW, // station upper digit switch
  input wire logic [3:0] STN_ONES_SW, // station lower digit switch
  input wire logic CONN_EN_STORED, // stored connection enable, addr 0
  input wire logic SERIAL_ERR_EVT, // serial-side error pulse
  input wire logic BUS_ERR_EVT, // fieldbus error pulse
  input wire cscd_pkg::cscd_cmd_t CMD, // incoming fieldbus command
  output cscd_pkg::cscd_cfg_t CFG, // latched configuration
  output logic RATE_625K, // rate decoded as 625 kbps
  output logic [6:0] XFER_BYTES, // transmission byte count
  output logic [4:0] MAX_UNITS, // attachable unit limit
  output logic CFG_VALID, // configuration latched
  output logic SETTING_ALARM, // setting-error alarm level
  output logic SERIAL_ERR_LED, // serial error indicator
  output logic GENERAL_ERR_LED, // fieldbus error indicator
  output logic CONN_EN_PEND, // pending connection enable to store
  output logic [15:0] DRV_IO, // relayed drive I/O signals
  output logic DRV_IO_STB, // relayed I/O strobe
  output logic IRQ // interrupt, high while unmasked bit set
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] bytes_of(input logic [1:0] code);
    case (code)
      2'h0: bytes_of = cscd_pkg::BYTES_16;
      2'h1: bytes_of = cscd_pkg::BYTES_32;
      2'h2: bytes_of = cscd_pkg::BYTES_48;
      default: bytes_of = cscd_pkg::BYTES_64;
    endcase
  endfunction

  function automatic logic rate_bad(input logic [3:0] rate);
    rate_bad = (rate >= cscd_pkg::RATE_BAD_MIN);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [16:0] pins_sync;
  logic [3:0] s_rate;
  logic [3:0] s_mode;
  logic [7:0] s_station;
  logic s_conn;

  cscd_sync #(.W(17)) u_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D({RATE_SW, MODE_SW, STN_TENS_SW, STN_ONES_SW, CONN_EN_STORED}),
    .Q(pins_sync)
  );

  assign s_rate = pins_sync[16:13];
  assign s_mode = pins_sync[12:9];
  assign s_station = pins_sync[8:1];
  assign s_conn = pins_sync[0];

  // ----------------------------------------------------------------------
  // Power-on load sequence
  // ----------------------------------------------------------------------
  cscd_pkg::cscd_state_t state_reg;
  cscd_pkg::cscd_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  cscd_pkg::cscd_cfg_t cfg_reg;
  cscd_pkg::cscd_cfg_t cfg_next;
  logic alarm_reg;
  logic alarm_next;
  logic setting_evt;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cfg_next = cfg_reg;
    alarm_next = alarm_reg;
    setting_evt = 1'b0;
    case (state_reg)
      cscd_pkg::ST_SETTLE: begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(cscd_pkg::SETTLE_CYCLES)) begin
          state_next = cscd_pkg::ST_LATCH;
        end
      end
      cscd_pkg::ST_LATCH: begin
        // Sampled once; later switch motion is never looked at again.
        cfg_next.rate = s_rate; // RULE_01
        // Mode bit 3 has no function, so only bits 0 to 2 are read.
        cfg_next.io8_mode = s_mode[cscd_pkg::MODE_IO8_BIT]; // RULE_05 RULE_07
        cfg_next.bytes_code = {s_mode[cscd_pkg::MODE_BYTES_HI],
                               s_mode[cscd_pkg::MODE_BYTES_LO]}; // RULE_06
        cfg_next.station = s_station; // RULE_08
        cfg_next.conn_en = s_conn; // RULE_12
        // Values 0 to 6 are unusable but raise nothing.
        alarm_next = rate_bad(s_rate); // RULE_03 RULE_04
        setting_evt = rate_bad(s_rate); // RULE_03
        state_next = cscd_pkg::ST_RUN;
      end
      cscd_pkg::ST_RUN: begin
        state_next = cscd_pkg::ST_RUN; // RULE_15
      end
      default: begin
        state_next = cscd_pkg::ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= cscd_pkg::ST_SETTLE;
      cnt_reg <= 8'h00;
      cfg_reg <= cscd_pkg::RST_CFG;
      alarm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cfg_reg <= cfg_next;
      alarm_reg <= alarm_next;
    end
  end

  assign CFG = cfg_reg;
  assign CFG_VALID = (state_reg == cscd_pkg::ST_RUN);
  assign SETTING_ALARM = alarm_reg;
  assign RATE_625K = (cfg_reg.rate == cscd_pkg::RATE_625K_CODE); // RULE_02
  assign XFER_BYTES = bytes_of(cfg_reg.bytes_code); // RULE_06
  assign MAX_UNITS = cfg_reg.io8_mode ? cscd_pkg::UNITS_8BIT
                                      : cscd_pkg::UNITS_16BIT; // RULE_05

  // ----------------------------------------------------------------------
  // I/O exchange relay
  // ----------------------------------------------------------------------
  logic [15:0] io_reg;
  logic [15:0] io_next;
  logic stb_reg;
  logic stb_next;

  always_comb begin
    io_next = io_reg;
    stb_next = 1'b0;
    if (CMD.valid && CMD.code == cscd_pkg::IO_EXCHANGE_CODE) begin
      io_next = CMD.io; // RULE_14
      stb_next = 1'b1; // RULE_14
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      io_reg <= 16'h0000;
      stb_reg <= 1'b0;
    end else begin
      io_reg <= io_next;
      stb_reg <= stb_next;
    end
  end

  assign DRV_IO = io_reg;
  assign DRV_IO_STB = stb_reg;

  // ----------------------------------------------------------------------
  // APB registers and interrupts
  // ----------------------------------------------------------------------
  logic [2:0] sts_reg;
  logic [2:0] sts_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic pend_reg;
  logic pend_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic wr_en;
  logic setup;
  logic [2:0] events;
  logic [2:0] clr;

  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign events = {BUS_ERR_EVT, SERIAL_ERR_EVT, setting_evt};

  always_comb begin
    mask_next = mask_reg;
    pend_next = pend_reg;
    clr = 3'h0;
    if (wr_en && PADDR == cscd_pkg::OFS_IRQ_STS) begin
      clr = PWDATA[2:0];
    end
    if (wr_en && PADDR == cscd_pkg::OFS_IRQ_MASK) begin
      mask_next = PWDATA[2:0];
    end
    // The stored copy only takes effect at the next power-on load.
    if (wr_en && PADDR == cscd_pkg::OFS_CONN_PEND) begin
      pend_next = PWDATA[0]; // RULE_12
    end
    // A new event in the clearing cycle survives the clear.
    sts_next = (sts_reg & ~clr) | events; // RULE_13
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (setup) begin
      err_next = 1'b0;
      case (PADDR)
        cscd_pkg::OFS_CONFIG: rdata_next = {16'h0000, cfg_reg};
        cscd_pkg::OFS_STATUS:
          rdata_next = {28'h000_0000, cfg_reg.conn_en, RATE_625K,
                        alarm_reg, CFG_VALID};
        cscd_pkg::OFS_IRQ_STS: rdata_next = {29'h0000_0000, sts_reg};
        cscd_pkg::OFS_IRQ_MASK: rdata_next = {29'h0000_0000, mask_reg};
        cscd_pkg::OFS_CONN_PEND: rdata_next = {31'h0000_0000, pend_reg};
        cscd_pkg::OFS_IO_DATA: rdata_next = {16'h0000, io_reg};
        default: begin
          rdata_next = cscd_pkg::RD_ZERO;
          err_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sts_reg <= 3'h0;
      mask_reg <= cscd_pkg::RST_IRQ_MASK;
      pend_reg <= 1'b0;
      rdata_reg <= cscd_pkg::RD_ZERO;
      err_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      mask_reg <= mask_next;
      pend_reg <= pend_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign PREADY = 1'b1;
  assign PRDATA = rdata_reg;
  assign PSLVERR = err_reg && PSEL && PENABLE;
  assign IRQ = |(sts_reg & mask_reg);
  assign CONN_EN_PEND = pend_reg;
  assign SERIAL_ERR_LED = sts_reg[cscd_pkg::IRQ_SERIAL]; // RULE_13
  assign GENERAL_ERR_LED = sts_reg[cscd_pkg::IRQ_BUS]; // RULE_13

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  localparam int AB = cscd_pkg::ALARM_BOUND;
  logic [3:0] rst_cnt_reg;
  logic [3:0] rst_cnt_next;

  always_comb begin
    rst_cnt_next = (rst_cnt_reg == 4'hF) ? rst_cnt_reg : rst_cnt_reg + 4'h1;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rst_cnt_reg <= 4'h0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_cfg_held_stable: assert property ( // RULE_01
    CFG_VALID |=> $stable(cfg_reg))
    else $error("Configuration changed after latch.");
  a_rate_seven_ok: assert property ( // RULE_02
    CFG_VALID && cfg_reg.rate == 4'h7 |-> RATE_625K && !alarm_reg)
    else $error("Rate seven not decoded as 625 kbps.");
  a_bad_rate_alarm: assert property ( // RULE_03
    CFG_VALID && cfg_reg.rate >= 4'h8 |-> alarm_reg)
    else $error("Bad rate without alarm.");
  a_low_rate_quiet: assert property ( // RULE_04
    CFG_VALID && cfg_reg.rate < 4'h7 |-> !alarm_reg)
    else $error("Alarm raised for low rate.");
  a_units_decode: assert property ( // RULE_05
    MAX_UNITS == (cfg_reg.io8_mode ? 5'h10 : 5'h08))
    else $error("Unit limit mismatch.");
  a_bytes_decode: assert property ( // RULE_06
    XFER_BYTES == 7'(16 * (cfg_reg.bytes_code + 1)))
    else $error("Byte count mismatch.");
  a_latch_from_pins: assert property ( // RULE_08
    state_reg == cscd_pkg::ST_LATCH |=>
      cfg_reg.station == $past(s_station) &&
      cfg_reg.conn_en == $past(s_conn))
    else $error("Station or connection not latched from pins.");
  a_alarm_timely: assert property ( // RULE_15
    rst_cnt_reg == 4'(AB) |-> CFG_VALID)
    else $error("Load not finished in time.");
  a_serial_led: assert property ( // RULE_13
    SERIAL_ERR_EVT |=> SERIAL_ERR_LED)
    else $error("Serial error not shown.");
  a_io_relay: assert property ( // RULE_14
    CMD.valid && CMD.code == 8'h20 |=> DRV_IO_STB && DRV_IO == $past(CMD.io))
    else $error("I/O exchange not relayed.");

  c_bad_rate: cover property (CFG_VALID && alarm_reg);
  c_irq_fire: cover property (IRQ);
  c_relay: cover property (DRV_IO_STB);
  c_slverr: cover property (PSLVERR);

endmodule

//--- cscd_pkg.sv
// Purpose: Shared constants and types for the switch configuration decoder.
// Assumes: One clock, synchronous active-high reset, APB register access.
// Notes: Byte offsets are word aligned; delay counts are in clock cycles.
package cscd_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_NS = 20;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int ALARM_BOUND = SETTLE_CYCLES + 4;

  // ----------------------------------------------------------------------
  // Switch codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] RATE_625K_CODE = 4'h7;
  localparam logic [3:0] RATE_BAD_MIN = 4'h8;
  localparam logic [7:0] IO_EXCHANGE_CODE = 8'h20;
  localparam logic [3:0] DEF_RATE = 4'h7;
  localparam logic [3:0] DEF_MODE = 4'h4;
  localparam logic [7:0] DEF_STATION = 8'h61;
  localparam logic [6:0] BYTES_16 = 7'h10;
  localparam logic [6:0] BYTES_32 = 7'h20;
  localparam logic [6:0] BYTES_48 = 7'h30;
  localparam logic [6:0] BYTES_64 = 7'h40;
  localparam logic [4:0] UNITS_16BIT = 5'h08;
  localparam logic [4:0] UNITS_8BIT = 5'h10;

  // ----------------------------------------------------------------------
  // Mode switch bit positions
  // ----------------------------------------------------------------------
  localparam int MODE_IO8_BIT = 0;
  localparam int MODE_BYTES_HI = 1;
  localparam int MODE_BYTES_LO = 2;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_CONN_PEND = 8'h10;
  localparam logic [7:0] OFS_IO_DATA = 8'h14;
  localparam int IRQ_W = 3;
  localparam int IRQ_SETTING = 0;
  localparam int IRQ_SERIAL = 1;
  localparam int IRQ_BUS = 2;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [3:0] rate;
    logic io8_mode;
    logic [1:0] bytes_code;
    logic [7:0] station;
    logic conn_en;
  } cscd_cfg_t;

  localparam cscd_cfg_t RST_CFG = '{DEF_RATE, 1'b0, 2'h1, DEF_STATION, 1'b0};

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] io;
  } cscd_cmd_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN = 2'b11
  } cscd_state_t;

endpackage

//--- cscd_sync.sv
// Purpose: Two-stage synchroniser for the switch and stored-parameter pins.
// Assumes: Inputs are slow static levels from outside the clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module cscd_sync #(
  parameter int W = 17
) (
  input wire logic CLK, // system clock
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic [W-1:0] D, // asynchronous level inputs
  output logic [W-1:0] Q // synchronised levels
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = D;
    q_next = meta_reg;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign Q = q_reg;

endmodule

//--- cscd_master_model.sv
// Purpose: Fieldbus master model that issues commands and error events.
// Assumes: Shares the converter clock; changes follow a rising edge.
// Notes: A released command bus shows inverted data, never the last value.
`timescale 1ns/100ps
module cscd_master_model (
  input wire logic clk, // system clock
  output cscd_pkg::cscd_cmd_t cmd, // command to the converter
  output logic serial_err_evt, // serial-side error pulse
  output logic bus_err_evt // fieldbus error pulse
);
  initial begin
    cmd = '0;
    serial_err_evt = 1'b0;
    bus_err_evt = 1'b0;
  end

  task automatic send(input logic [7:0] code, input logic [15:0] io);
    @(posedge clk);
    cmd <= '{1'b1, code, io};
  endtask

  task automatic idle();
    @(posedge clk);
    cmd <= '{1'b0, ~cmd.code, ~cmd.io};
  endtask

  task automatic err_pulse(input logic on_bus);
    @(posedge clk);
    bus_err_evt <= on_bus;
    serial_err_evt <= ~on_bus;
    @(posedge clk);
    bus_err_evt <= 1'b0;
    serial_err_evt <= 1'b0;
  endtask
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the switch configuration decoder.
// Assumes: Power cycles are modelled by SYS_RST.
// Notes: Relayed I/O results are checked against a queue of notes.
`timescale 1ns/100ps
module tb;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, conn_stored;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] rate_sw, mode_sw, tens_sw, ones_sw;
  cscd_pkg::cscd_cmd_t cmd;
  cscd_pkg::cscd_cfg_t cfg, exp_cfg;
  logic r625, cfg_valid, alarm, ser_led, gen_led, conn_pend, io_stb, irq;
  logic ser_evt, bus_evt, err;
  logic [6:0] xfer_bytes;
  logic [4:0] max_units;
  logic [15:0] drv_io;
  logic [15:0] exp_q[$];
  int err_total, compares;
  integer seed = 32'h3053_9679;
  logic [3:0] rates [8] = '{4'h7, 4'h0, 4'h6, 4'h8, 4'hF, 4'h9, 4'h3, 4'h7};

  cscd_top dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RATE_SW(rate_sw),
    .MODE_SW(mode_sw), .STN_TENS_SW(tens_sw), .STN_ONES_SW(ones_sw),
    .CONN_EN_STORED(conn_stored), .SERIAL_ERR_EVT(ser_evt),
    .BUS_ERR_EVT(bus_evt), .CMD(cmd), .CFG(cfg), .RATE_625K(r625),
    .XFER_BYTES(xfer_bytes), .MAX_UNITS(max_units), .CFG_VALID(cfg_valid),
    .SETTING_ALARM(alarm), .SERIAL_ERR_LED(ser_led),
    .GENERAL_ERR_LED(gen_led), .CONN_EN_PEND(conn_pend), .DRV_IO(drv_io),
    .DRV_IO_STB(io_stb), .IRQ(irq));

  cscd_master_model master (.clk(clk), .cmd(cmd),
    .serial_err_evt(ser_evt), .bus_err_evt(bus_evt));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic power_cycle(input logic [3:0] r, m, t, o, input logic c);
    int n;
    @(posedge clk);
    sys_rst <= 1'b1;
    rate_sw <= r;
    mode_sw <= m;
    tens_sw <= t;
    ones_sw <= o;
    conn_stored <= c;
    repeat (2) @(posedge clk);
    check("cfg_reset", cfg, cscd_pkg::RST_CFG);
    check("valid_reset", cfg_valid, 1'b0);
    sys_rst <= 1'b0;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("valid_time", 32'(n <= cscd_pkg::ALARM_BOUND + 1), 1);
    exp_cfg = '{r, m[0], {m[1], m[2]}, {t, o}, c};
    check("cfg", cfg, exp_cfg);
    check("rate_625k", r625, r == 4'h7);
    check("alarm", alarm, r >= 4'h8);
    check("bytes", xfer_bytes, ({m[1], m[2]} + 1) * 16);
    check("units", max_units, m[0] ? 16 : 8);
    apb(1'b0, cscd_pkg::OFS_STATUS, 32'h0000_0000);
    check("status", rd,
          {28'h000_0000, c, r == 4'h7, r >= 4'h8, 1'b1});
    apb(1'b0, cscd_pkg::OFS_IRQ_STS, 32'h0000_0000);
    check("irq_sts", rd, 32'(r >= 4'h8));
    rate_sw <= ~r;
    mode_sw <= ~m;
    tens_sw <= ~t;
    conn_stored <= ~c;
    repeat (10) @(posedge clk);
    check("cfg_hold", cfg, exp_cfg);
    check("alarm_hold", alarm, r >= 4'h8);
  endtask

  // ----------------------------------------------------------------------
  // Relay monitor and watchdog
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (io_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare_strobe", 1, 0);
      end else begin
        check("drv_io", drv_io, exp_q.pop_front());
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [3:0] m;
    logic [31:0] v;
    logic [7:0] s;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rate_sw = 4'h7;
    mode_sw = cscd_pkg::DEF_MODE;
    tens_sw = 4'h6;
    ones_sw = 4'h1;
    conn_stored = 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      m = {v[8], i[0], i[1], i[2]};
      // The only station on the bus is kept inside 03h to EFh.
      s = 8'h03 + 8'(v[7:0] % 8'hED);
      power_cycle(rates[i], m, s[7:4], s[3:0], i[0]);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped_err", err, 1'b1);
    check("unmapped_data", rd, 32'h0000_0000);
    apb(1'b1, cscd_pkg::OFS_CONN_PEND, 32'h0000_0001);
    @(posedge clk);
    check("conn_pend", conn_pend, 1'b1);
    check("conn_live", cfg.conn_en, exp_cfg.conn_en);
    apb(1'b1, cscd_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    master.err_pulse(1'b1);
    @(posedge clk);
    check("gen_led", gen_led, 1'b1);
    check("ser_led_off", ser_led, 1'b0);
    check("irq_masked", irq, 1'b0);
    apb(1'b1, cscd_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    @(posedge clk);
    check("irq_on", irq, 1'b1);
    apb(1'b1, cscd_pkg::OFS_IRQ_STS, 32'h0000_0004);
    @(posedge clk);
    check("irq_clear", irq, 1'b0);
    check("gen_led_clear", gen_led, 1'b0);
    master.err_pulse(1'b0);
    @(posedge clk);
    check("ser_led", ser_led, 1'b1);
    check("irq_ser_masked", irq, 1'b0);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      exp_q.push_back(v[15:0]);
      master.send(cscd_pkg::IO_EXCHANGE_CODE, v[15:0]);
    end
    master.send(8'h0E, v[31:16]);
    master.send(8'h0F, v[31:16]);
    master.send(8'h00, v[31:16]);
    master.idle();
    repeat (4) @(posedge clk);
    check("relay_left", exp_q.size(), 0);
    summarize();
  end
endmodule
